// ### src/sfw_pkg.sv
// Purpose: Shared constants and types for the stream FIFO write side
// Assumes: Byte-multiple data width, fixed sideband widths
// Notes:   All numbers used by the design live here

package sfw_pkg;

  // ----------------------------------------------------------------
  // Payload geometry
  // ----------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int BYTE_W  = 8;
  localparam int STRB_W  = DATA_W / BYTE_W;
  localparam int ID_W    = 4;
  localparam int DEST_W  = 4;
  localparam int USER_W  = 4;

  // ----------------------------------------------------------------
  // Buffer, count and flag settings
  // ----------------------------------------------------------------
  localparam int          FIFO_DEPTH = 4;
  localparam int          CNT_W      = 32;
  localparam int          SYNC_W     = 2;
  localparam bit [CNT_W-1:0] PFULL_DEF = 32'h0000_0003;

  // ----------------------------------------------------------------
  // Error injection bit positions
  // ----------------------------------------------------------------
  localparam int SBIT_POS = 0;
  localparam int DBIT_POS = 1;

  // ----------------------------------------------------------------
  // One stream beat
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
    logic [STRB_W-1:0] keep;
    logic              last;
    logic [ID_W-1:0]   id;
    logic [DEST_W-1:0] dest;
    logic [USER_W-1:0] user;
  } sfw_beat_s;

  localparam int BEAT_W = $bits(sfw_beat_s);

endpackage

// ### src/sfw_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, clock enable freezes all state
// Notes:   Count is a register, exact occupancy

`timescale 1ns/1ps

module sfw_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          clk_en,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [CW-1:0]      count
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_ptr_q];
  assign count     = cnt_q;
  assign push      = clk_en & in_valid & in_ready;
  assign pop       = clk_en & out_valid & out_ready;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and occupancy
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule // sfw_fifo

// ### src/sfw_top.sv
// Purpose: Write side of a stream data FIFO with fill flags
// Assumes: Upstream master is logic on clk_sys; read side paced by
//          an outside read clock sampled here
// Notes:   Single common clock build; see port list
//
// Functional notes
// - A transfer counts only when valid and ready are both high.
// - Ready is raised only when one transfer can be stored now.
// - All stream signals are sampled and driven on the rising clock edge.
// - Reset is active low and asynchronous.
// - Data is whole bytes; strobe and keep carry one bit per byte.
// - Bytes with keep low are null and are zeroed in storage.
// - Strobe bits travel with their bytes unchanged.
// - Last marks packet end and is kept through the buffer.
// - User, id and dest travel unchanged with each transfer.
// - A 32-bit word count is given in the write clock domain.
// - Almost full is high when one more write fills the buffer, with packet mode off; packet mode holds it low.
// - Programmable full is high while count is at or above threshold.
// - Single-bit inject flips one stored bit when ECC is enabled and double-bit inject is low.
// - Double-bit inject flips two stored bits when ECC is enabled.
// - Common clock build has no separate per-interface clock inputs; this one also takes rd_link_clk, a read clock sampled on clk_sys.
// - One global clock, low reset and clock enable drive everything.

`timescale 1ns/1ps

module sfw_top #(
  parameter int DEPTH       = sfw_pkg::FIFO_DEPTH,
  parameter bit ECC_EN      = 1'b1,
  parameter bit PACKET_MODE = 1'b0
) (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic                      clk_en,
  input  wire logic                      s_tvalid,
  output logic                           s_tready,
  input  wire sfw_pkg::sfw_beat_s        s_beat,
  input  wire logic                      inject_sbit,
  input  wire logic                      inject_dbit,
  input  wire logic [sfw_pkg::CNT_W-1:0] prog_full_thresh,
  input  wire logic                      rd_link_clk,
  input  wire logic                      m_tready,
  output logic                           m_tvalid,
  output sfw_pkg::sfw_beat_s             m_beat,
  output logic [sfw_pkg::CNT_W-1:0]      wr_data_count,
  output logic                           almost_full,
  output logic                           prog_full
);

  localparam int FCW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                          rst_done_q;
  logic                          fifo_in_ready;
  logic                          fifo_out_valid;
  logic                          fifo_out_ready;
  logic [FCW-1:0]                fifo_cnt;
  sfw_pkg::sfw_beat_s            fifo_in;
  sfw_pkg::sfw_beat_s            fifo_out;
  logic [sfw_pkg::DATA_W-1:0]    masked_data;
  logic [sfw_pkg::DATA_W-1:0]    err_mask;
  logic                          accept;
  logic                          pop;
  logic [sfw_pkg::SYNC_W-1:0]    lk_sync_q;
  logic                          lk_prev_q;
  logic                          lk_rise;
  logic [sfw_pkg::SYNC_W-1:0]    rdy_sync_q;
  logic                          rdy_s;
  sfw_pkg::sfw_beat_s            m_beat_q;
  logic                          m_tvalid_q;
  logic [sfw_pkg::CNT_W-1:0]     cnt_ext;

  // ----------------------------------------------------------------
  // Reset release tracking
  // ----------------------------------------------------------------
  // First enabled edge after release opens the write port
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_done_q <= 1'b0;
    end else if (clk_en) begin
      rst_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write handshake
  // ----------------------------------------------------------------
  // Ready only when storage is free, out of reset, and enabled
  assign s_tready = fifo_in_ready & rst_done_q & clk_en;
  assign accept   = s_tvalid & s_tready;

  // ----------------------------------------------------------------
  // Null byte masking
  // ----------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < sfw_pkg::STRB_W; gb++) begin : g_byte
      assign masked_data[gb*sfw_pkg::BYTE_W +: sfw_pkg::BYTE_W] =
        s_beat.keep[gb] ? s_beat.data[gb*sfw_pkg::BYTE_W +: sfw_pkg::BYTE_W]
                        : '0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Error injection
  // ----------------------------------------------------------------
  always_comb begin
    err_mask = '0;
    if (ECC_EN && inject_sbit && !inject_dbit) begin
      err_mask[sfw_pkg::SBIT_POS] = 1'b1;
    end
    if (ECC_EN && inject_dbit) begin
      err_mask[sfw_pkg::SBIT_POS] = 1'b1;
      err_mask[sfw_pkg::DBIT_POS] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Word into the buffer
  // ----------------------------------------------------------------
  always_comb begin
    fifo_in      = s_beat;
    fifo_in.data = masked_data ^ err_mask;
  end

  sfw_fifo #(
    .W     (sfw_pkg::BEAT_W),
    .DEPTH (DEPTH),
    .CW    (FCW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .in_valid  (accept),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out),
    .count     (fifo_cnt)
  );

  // ----------------------------------------------------------------
  // Read clock and read ready sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lk_sync_q <= '0;
      lk_prev_q <= 1'b0;
    end else if (clk_en) begin
      lk_sync_q <= {lk_sync_q[0], rd_link_clk};
      lk_prev_q <= lk_sync_q[1];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdy_sync_q <= '0;
    end else if (clk_en) begin
      rdy_sync_q <= {rdy_sync_q[0], m_tready};
    end
  end

  assign lk_rise = lk_sync_q[1] & ~lk_prev_q;
  assign rdy_s   = rdy_sync_q[1];

  // ----------------------------------------------------------------
  // Drain on each sampled read clock rising edge while read ready is high
  // ----------------------------------------------------------------
  assign fifo_out_ready = rdy_s & lk_rise;
  assign pop            = fifo_out_valid & fifo_out_ready & clk_en;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      m_beat_q <= '0;
    end else if (pop) begin
      m_beat_q <= fifo_out;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      m_tvalid_q <= 1'b0;
    end else if (clk_en) begin
      m_tvalid_q <= pop;
    end
  end

  assign m_beat   = m_beat_q;
  assign m_tvalid = m_tvalid_q;

  // ----------------------------------------------------------------
  // Count and flags
  // ----------------------------------------------------------------
  assign cnt_ext       = sfw_pkg::CNT_W'(fifo_cnt);
  assign wr_data_count = cnt_ext;
  assign almost_full   = !PACKET_MODE &&
                         (fifo_cnt == FCW'(DEPTH - 1));
  assign prog_full     = (cnt_ext >= prog_full_thresh);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ready_full: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (fifo_cnt == FCW'(DEPTH)) |-> !s_tready)
    else $error("ready high while buffer full");

  a_ready_reset: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !rst_done_q |-> !s_tready)
    else $error("ready high before reset release");

  a_ready_enable: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !clk_en |-> !s_tready)
    else $error("ready high with clock enable low");

  a_accept_count: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (accept && !pop) |=> (wr_data_count == $past(wr_data_count) + 1))
    else $error("accepted write not counted");

  a_pop_count: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (pop && !accept) |=> (wr_data_count == $past(wr_data_count) - 1))
    else $error("read not reflected in count");

  a_idle_count: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (!accept && !pop) |=> $stable(wr_data_count))
    else $error("count moved without a transfer");

  a_afull_fill: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (almost_full && accept && !pop) |=> !s_tready)
    else $error("almost full did not precede full");

  a_pfull_low: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (wr_data_count < prog_full_thresh) |-> !prog_full)
    else $error("prog full high below threshold");

  a_null_byte: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (accept && !s_beat.keep[0] && !inject_sbit && !inject_dbit)
      |-> (fifo_in.data[sfw_pkg::BYTE_W-1:0] == '0))
    else $error("null byte not cleared");

  a_sbit_flip: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (accept && ECC_EN && inject_sbit && !inject_dbit)
      |-> ($countones(fifo_in.data ^ masked_data) == 1))
    else $error("single bit inject did not flip one bit");

  a_dbit_flip: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (accept && ECC_EN && inject_dbit)
      |-> ($countones(fifo_in.data ^ masked_data) == 2))
    else $error("double bit inject did not flip two bits");

  a_side_carry: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    accept |-> (fifo_in.id == s_beat.id && fifo_in.dest == s_beat.dest &&
                fifo_in.user == s_beat.user && fifo_in.strb == s_beat.strb))
    else $error("sideband altered on write");

  a_last_kept: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    pop |=> (m_tvalid && m_beat.last == $past(fifo_out.last)))
    else $error("last lost on read");

  a_pfull_high: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (wr_data_count >= prog_full_thresh) |-> prog_full)
    else $error("prog full low at or above threshold");

  a_afull_set: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (!PACKET_MODE && wr_data_count == sfw_pkg::CNT_W'(DEPTH - 1))
      |-> almost_full)
    else $error("almost full low one word before full");

  a_afull_clear: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (wr_data_count != sfw_pkg::CNT_W'(DEPTH - 1)) |-> !almost_full)
    else $error("almost full high at wrong fill");

  a_ready_free: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (rst_done_q && clk_en && fifo_cnt != FCW'(DEPTH)) |-> s_tready)
    else $error("ready low with room free");

  a_enable_freeze: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !clk_en |=> ($stable(wr_data_count) && $stable(m_beat)))
    else $error("state moved with clock enable low");

  a_beat_hold: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !pop |=> $stable(m_beat))
    else $error("read word changed without a pop");

  a_tvalid_src: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (m_tvalid && $past(clk_en)) |-> $past(pop))
    else $error("read valid without a pop");

  a_data_kept: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (accept && s_beat.keep[0] && !inject_sbit && !inject_dbit)
      |-> (fifo_in.data[sfw_pkg::BYTE_W-1:0] ==
           s_beat.data[sfw_pkg::BYTE_W-1:0]))
    else $error("kept byte altered on write");

  c_fill_full: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    fifo_cnt == FCW'(DEPTH));

  c_drain_word: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    pop ##1 m_tvalid);

  c_inject_dbit: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    accept && inject_dbit);

  c_pfull_rise: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(prog_full));

  c_null_write: cover property (
    @(posedge clk_sys) disable iff (!arst_n)
    accept && !(&s_beat.keep));

endmodule // sfw_top

// ### verif/sfw_src_model.sv
// Purpose: Upstream stream master model for the FIFO write side
// Assumes: Called from the bench just after a clk_sys rising edge
// Notes:   Holds a beat until taken; idle lines show scrambled values

`timescale 1ns/1ps

module sfw_src_model (
  input  wire logic          clk_sys,
  input  wire logic          s_tready,
  output logic               s_tvalid,
  output sfw_pkg::sfw_beat_s s_beat,
  output logic               inject_sbit,
  output logic               inject_dbit
);
  initial begin
    s_tvalid    = 1'b0;
    s_beat      = '0;
    inject_sbit = 1'b0;
    inject_dbit = 1'b0;
  end

  // Hold beat and inject bits until the handshake edge
  task automatic send(input sfw_pkg::sfw_beat_s b, input logic sb,
                      input logic db);
    logic ok;
    s_tvalid    <= 1'b1;
    s_beat      <= b;
    inject_sbit <= sb;
    inject_dbit <= db;
    do begin
      @(negedge clk_sys);
      ok = (s_tready === 1'b1);
      @(posedge clk_sys);
    end while (!ok);
  endtask

  // Release after a handshake only
  task automatic idle();
    s_tvalid    <= 1'b0;
    s_beat      <= ~s_beat;
    inject_sbit <= 1'b0;
    inject_dbit <= 1'b0;
  endtask
endmodule // sfw_src_model

// ### verif/test_sfw_top.sv
// Purpose: Self-checking bench for the stream FIFO write side
// Assumes: Default depth, ECC on, packet mode off
// Notes:   Beats noted at send time, checked as they leave

`timescale 1ns/1ps

module test_sfw_top;
  localparam int DEP = sfw_pkg::FIFO_DEPTH;
  logic               clk_sys = 1'b0;
  logic               arst_n;
  logic               clk_en;
  logic               s_tvalid;
  logic               s_tready;
  sfw_pkg::sfw_beat_s s_beat;
  logic               inject_sbit;
  logic               inject_dbit;
  logic [31:0]        thresh;
  logic               rd_link_clk;
  logic               m_tready;
  logic               m_tvalid;
  sfw_pkg::sfw_beat_s m_beat;
  logic [31:0]        wr_data_count;
  logic               almost_full;
  logic               prog_full;
  logic               lnk_run;
  logic               rnd_on;
  logic               acc_p = 1'b0;
  int                 exp_cnt = 0;
  int                 error_cnt = 0;
  int                 comparisons = 0;
  sfw_pkg::sfw_beat_s exp_q[$];

  sfw_top sfw_top_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .s_tvalid(s_tvalid), .s_tready(s_tready), .s_beat(s_beat),
    .inject_sbit(inject_sbit), .inject_dbit(inject_dbit),
    .prog_full_thresh(thresh), .rd_link_clk(rd_link_clk),
    .m_tready(m_tready), .m_tvalid(m_tvalid), .m_beat(m_beat),
    .wr_data_count(wr_data_count), .almost_full(almost_full),
    .prog_full(prog_full)
  );

  sfw_src_model sfw_src_model_inst (
    .clk_sys(clk_sys), .s_tready(s_tready), .s_tvalid(s_tvalid),
    .s_beat(s_beat), .inject_sbit(inject_sbit), .inject_dbit(inject_dbit)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    rd_link_clk = 1'b0;
    #137;
    forever #400 rd_link_clk = lnk_run ? ~rd_link_clk : 1'b0;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic sfw_pkg::sfw_beat_s exp_of(sfw_pkg::sfw_beat_s b,
                                                logic sb, logic db);
    sfw_pkg::sfw_beat_s e;
    e = b;
    for (int i = 0; i < sfw_pkg::STRB_W; i++) begin
      if (!b.keep[i]) e.data[i*8 +: 8] = 8'h00;
    end
    if (db) e.data[1:0] = ~e.data[1:0];
    else if (sb) e.data[0] = ~e.data[0];
    return e;
  endfunction

  always @(negedge clk_sys) begin
    if (!arst_n) begin
      exp_cnt = 0;
      acc_p = 1'b0;
      chk("tready_rst", s_tready, 1'b0);
    end else begin
      exp_cnt = exp_cnt + int'(acc_p) - int'(m_tvalid === 1'b1);
      acc_p = (s_tvalid === 1'b1) && (s_tready === 1'b1);
      if (m_tvalid === 1'b1) begin
        if (exp_q.size() == 0) chk("extra_beat", 1, 0);
        else chk("m_beat", m_beat, exp_q.pop_front());
      end
    end
    chk("count", wr_data_count, exp_cnt);
    chk("almost_full", almost_full, exp_cnt == DEP - 1);
    chk("prog_full", prog_full, exp_cnt >= thresh);
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic put(input logic last, input logic sb, input logic db);
    logic [63:0]        r;
    sfw_pkg::sfw_beat_s b;
    r = {$urandom, $urandom};
    b = r[sfw_pkg::BEAT_W-1:0];
    b.last = last;
    exp_q.push_back(exp_of(b, sb, db));
    sfw_src_model_inst.send(b, sb, db);
  endtask

  task automatic drain();
    for (int k = 0; k < 600 && exp_q.size() != 0; k++) @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
    chk("drained", exp_q.size(), 0);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #2000000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    void'($urandom(37306));
    arst_n   = 1'b0;
    clk_en   = 1'b1;
    m_tready = 1'b0;
    lnk_run  = 1'b0;
    thresh   = sfw_pkg::PFULL_DEF;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < DEP; i++) put(i == DEP - 1, i[0], i[1]);
    fork
      put(1'b0, 1'b1, 1'b0);
      begin
        repeat (4) begin
          @(negedge clk_sys);
          chk("tready_full", s_tready, 1'b0);
        end
        @(posedge clk_sys);
        lnk_run  <= 1'b1;
        m_tready <= 1'b1;
      end
    join
    sfw_src_model_inst.idle();
    drain();
    clk_en <= 1'b0;
    @(negedge clk_sys);
    chk("tready_en", s_tready, 1'b0);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    thresh <= 32'h0000_0001 + ($urandom % 4);
    rnd_on = 1'b1;
    fork
      begin
        for (int i = 0; i < 12; i++) begin
          put(1'($urandom), 1'($urandom), 1'($urandom));
        end
        sfw_src_model_inst.idle();
        rnd_on = 1'b0;
      end
      while (rnd_on) begin
        @(posedge clk_sys);
        m_tready <= 1'($urandom);
      end
    join
    @(posedge clk_sys);
    m_tready <= 1'b1;
    drain();
    lnk_run <= 1'b0;
    repeat (20) @(posedge clk_sys);
    put(1'b0, 1'b0, 1'b0);
    put(1'b1, 1'b0, 1'b1);
    sfw_src_model_inst.idle();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    exp_q.delete();
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end
endmodule // test_sfw_top
